// *** pllcs_pkg.sv ***
// constants and types shared by the pll controller sequencer host
package pllcs_pkg;
    // device register bases and offsets
    localparam logic [31:0] SYS_BASE = 32'h01C4_0800;
    localparam logic [31:0] MEM_BASE = 32'h01C4_0C00;
    localparam logic [11:0] OFF_CTL = 12'h100;
    localparam logic [11:0] OFF_MULT = 12'h110;
    localparam logic [11:0] OFF_DIV1 = 12'h118;
    localparam logic [11:0] OFF_DIV2 = 12'h11C;
    localparam logic [11:0] OFF_POST_DIVIDER_REG = 12'h128;
    localparam logic [11:0] OFF_CMD = 12'h138;
    localparam logic [11:0] OFF_STAT = 12'h13C;
    // bit positions inside pll_control_reg, command_reg, controller_status_reg
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_PWRDN_BIT = 1;
    localparam int CTL_RST_BIT = 3;
    localparam int CTL_DIS_BIT = 4;
    localparam int CTL_ENSRC_BIT = 5;
    localparam int CTL_CLOCK_INPUT_MODE_BIT_BIT = 8;
    localparam int CMD_GO_SET_BIT_BIT = 0;
    localparam int STAT_GO_STATUS_BIT_BIT = 0;
    // software-side register offsets
    localparam logic [7:0] SW_CTRL = 8'h00;
    localparam logic [7:0] SW_MULT = 8'h04;
    localparam logic [7:0] SW_POST_DIVIDER_REG = 8'h08;
    localparam logic [7:0] SW_DIV1 = 8'h0C;
    localparam logic [7:0] SW_DIV2 = 8'h10;
    localparam logic [7:0] SW_STAB = 8'h14;
    localparam logic [7:0] SW_RSTW = 8'h18;
    localparam logic [7:0] SW_LOCK = 8'h1C;
    localparam logic [7:0] SW_STATUS = 8'h20;
    // software control fields
    localparam int CF_START = 0;
    localparam int CF_OP = 1;
    localparam int CF_TARGET = 3;
    localparam int CF_CLOCK_INPUT_MODE_BIT = 4;
    localparam int CF_POST_DIVIDER_REG_EN = 5;
    localparam int CF_DIV_EN = 6;
    // software status fields
    localparam int SF_BUSY = 0;
    localparam int SF_DONE = 1;
    localparam int SF_ERR = 2;
    localparam int SF_WARN = 3;
    localparam int SF_STEP = 8;
    // reset values of the software registers
    localparam logic [31:0] RV_MULT = 32'h0000_0010;
    localparam logic [31:0] RV_POST_DIVIDER_REG = 32'h0000_8000;
    localparam logic [31:0] RV_DIV1 = 32'h0000_8009;
    localparam logic [31:0] RV_DIV2 = 32'h0000_8001;
    localparam logic [15:0] RV_STAB = 16'h0100;
    localparam logic [15:0] RV_RSTW = 16'h0040;
    localparam logic [15:0] RV_LOCK = 16'h0800;
    // bypass settle time: four reference cycles at 27 MHz
    localparam int XTAL_PERIOD_PS = 37037;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int BYPASS_XTAL_CYC = 4;
    localparam int BYPASS_CYC = (BYPASS_XTAL_CYC * XTAL_PERIOD_PS + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    // sequence operations
    typedef enum logic [1:0] {OP_INIT = 2'h0, OP_MULT = 2'h1, OP_DIV = 2'h2} pllcs_op_t;
    // step list of the sequence
    localparam logic [4:0] STP_CLOCK_INPUT_MODE_BIT = 5'h00;
    localparam logic [4:0] STP_ENSRC_CLR = 5'h01;
    localparam logic [4:0] STP_EN_CLR = 5'h02;
    localparam logic [4:0] STP_BYP_WAIT = 5'h03;
    localparam logic [4:0] STP_RST_CLR = 5'h04;
    localparam logic [4:0] STP_DIS_SET = 5'h05;
    localparam logic [4:0] STP_PWRDN_CLR = 5'h06;
    localparam logic [4:0] STP_DIS_CLR = 5'h07;
    localparam logic [4:0] STP_STAB_WAIT = 5'h08;
    localparam logic [4:0] STP_MULT = 5'h09;
    localparam logic [4:0] STP_POST_DIVIDER_REG = 5'h0A;
    localparam logic [4:0] STP_GO_IDLE = 5'h0B;
    localparam logic [4:0] STP_DIV1 = 5'h0C;
    localparam logic [4:0] STP_DIV2 = 5'h0D;
    localparam logic [4:0] STP_GO_SET_BIT = 5'h0E;
    localparam logic [4:0] STP_GO_DONE = 5'h0F;
    localparam logic [4:0] STP_RST_WAIT = 5'h10;
    localparam logic [4:0] STP_RST_SET = 5'h11;
    localparam logic [4:0] STP_LOCK_WAIT = 5'h12;
    localparam logic [4:0] STP_EN_SET = 5'h13;
    localparam logic [4:0] STP_END = 5'h14;
    // kind of a step
    typedef enum logic [1:0] {K_WR = 2'h0, K_WAIT = 2'h1, K_POLL = 2'h2} pllcs_kind_t;
    // sequencer states
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_STEP = 5'h02,
        S_WAIT = 5'h04,
        S_READ = 5'h08,
        S_CHECK = 5'h10
    } pllcs_state_t;
endpackage

// *** pllcs_host.sv ***
// host sequencer that programs a pll controller through its register port
// Functional notes
// - clear enable-source, then pll select, to enter bypass first.
// - wait four reference cycles after selecting bypass.
// - clear pll reset bit once bypass holds, before reprogramming.
// - from power-down, set output disable after reset and before power-up.
// - clear power-down, then clear output disable.
// - wait stabilization time after enabling outputs, before the multiplier.
// - write multiplier; post-divider only on system controller and if non-default; the host writes it on system runs with the post-divider enable field set.
// - write both divider ratios, then set go bit.
// - go status stays set during transition; wait for it to clear.
// - after reset time, set pll reset bit to release the pll.
// - after lock time, set pll select bit to leave bypass.
// - first init step writes the clock input mode bit.
// - multiplier change skips disable, power-up and stabilization steps.
// - post-divider of the memory-side controller is never used.
// - memory controller in reset stays there until clocks are set.
// - running memory controller must be quiesced before reprogramming.
// - halt other peripherals before changing the system pll; the host runs anyway and only sets the warn flag.
// - confirm go status is clear before a divider change.
//
// Our own choices: strobed register access and the address map.
module pllcs_host
    import pllcs_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int POLL_MAX = 1024
)(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    input wire logic mem_quiet,
    input wire logic periph_quiet,
    output logic [31:0] dev_addr,
    output logic [31:0] dev_wdata,
    output logic dev_wr,
    output logic dev_rd,
    input wire logic [31:0] dev_rdata
);
    import pllcs_pkg::*;

    // elaboration check: wait and poll counters are 16 bits wide
    if (CNT_W < 8 || CNT_W > 16 || POLL_MAX < 1 || POLL_MAX >= (1 << 16))
    begin : g_bad_params
        $error("pllcs_host: unsupported parameter values");
    end

    pllcs_state_t state_q;
    pllcs_op_t op_q;
    logic [4:0] step_q;
    logic target_q, clock_input_mode_bit_q, pd_en_q, div_en_q;
    logic busy_q, done_q, err_q, warn_q;
    logic [31:0] mult_q, post_divider_reg_q, div1_q, div2_q;
    logic [15:0] stab_q, rstw_q, lock_q;
    logic [15:0] wait_q;
    logic [15:0] poll_q;
    logic [31:0] ctl_q;
    logic [31:0] base;
    logic start_ok;
    logic start_req;

    // is a step part of the chosen operation
    function automatic logic step_used(input logic [4:0] s, input pllcs_op_t op,
        input logic tgt, input logic pd, input logic dv);
        logic divs;
        divs = (s >= STP_GO_IDLE) && (s <= STP_GO_DONE);
        if (op == OP_DIV)
            return divs;
        if (s == STP_CLOCK_INPUT_MODE_BIT || s == STP_DIS_SET || s == STP_PWRDN_CLR || s == STP_STAB_WAIT)
            return op == OP_INIT;
        if (s == STP_POST_DIVIDER_REG)
            return pd && !tgt;
        if (divs)
            return dv && tgt;
        return s < STP_END;
    endfunction

    // what a step does
    function automatic pllcs_kind_t step_kind(input logic [4:0] s);
        if (s == STP_BYP_WAIT || s == STP_STAB_WAIT || s == STP_RST_WAIT || s == STP_LOCK_WAIT)
            return K_WAIT;
        if (s == STP_GO_IDLE || s == STP_GO_DONE)
            return K_POLL;
        return K_WR;
    endfunction

    // control word after a control-register step; other steps leave it alone
    function automatic logic [31:0] ctl_after(input logic [4:0] s, input logic [31:0] c);
        logic [31:0] n;
        n = c;
        case (s)
            STP_ENSRC_CLR: n[CTL_ENSRC_BIT] = 1'b0;
            STP_EN_CLR: n[CTL_EN_BIT] = 1'b0;
            STP_RST_CLR: n[CTL_RST_BIT] = 1'b0;
            STP_DIS_SET: n[CTL_DIS_BIT] = 1'b1;
            STP_PWRDN_CLR: n[CTL_PWRDN_BIT] = 1'b0;
            STP_DIS_CLR: n[CTL_DIS_BIT] = 1'b0;
            STP_RST_SET: n[CTL_RST_BIT] = 1'b1;
            STP_EN_SET: n[CTL_EN_BIT] = 1'b1;
            default: n = c;
        endcase
        return n;
    endfunction

    assign base = target_q ? MEM_BASE : SYS_BASE;
    assign start_req = sw_wr && sw_addr == SW_CTRL && sw_wdata[CF_START];
    // dividers of the system controller are fixed, a quiet memory side is a must for memory-side runs
    assign start_ok = !(sw_wdata[CF_TARGET] && !mem_quiet)
        && !(pllcs_op_t'(sw_wdata[CF_OP +: 2]) == OP_DIV && !sw_wdata[CF_TARGET])
        && sw_wdata[CF_OP +: 2] != 2'h3;

    // software-written settings, held while a sequence runs
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mult_q <= RV_MULT;
            post_divider_reg_q <= RV_POST_DIVIDER_REG;
            div1_q <= RV_DIV1;
            div2_q <= RV_DIV2;
            stab_q <= RV_STAB;
            rstw_q <= RV_RSTW;
            lock_q <= RV_LOCK;
        end
        else if (sw_wr && !busy_q)
        begin
            case (sw_addr)
                SW_MULT: mult_q <= sw_wdata;
                SW_POST_DIVIDER_REG: post_divider_reg_q <= sw_wdata;
                SW_DIV1: div1_q <= sw_wdata;
                SW_DIV2: div2_q <= sw_wdata;
                SW_STAB: stab_q <= sw_wdata[15:0];
                SW_RSTW: rstw_q <= sw_wdata[15:0];
                SW_LOCK: lock_q <= sw_wdata[15:0];
                default: ;
            endcase
        end
    end

    // software read port, data one cycle after the strobe
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            sw_rdata <= 32'h0000_0000;
        else if (sw_rd)
        begin
            case (sw_addr)
                SW_CTRL: sw_rdata <= {25'h0, div_en_q, pd_en_q, clock_input_mode_bit_q, target_q, op_q, 1'b0};
                SW_MULT: sw_rdata <= mult_q;
                SW_POST_DIVIDER_REG: sw_rdata <= post_divider_reg_q;
                SW_DIV1: sw_rdata <= div1_q;
                SW_DIV2: sw_rdata <= div2_q;
                SW_STAB: sw_rdata <= {16'h0, stab_q};
                SW_RSTW: sw_rdata <= {16'h0, rstw_q};
                SW_LOCK: sw_rdata <= {16'h0, lock_q};
                SW_STATUS: sw_rdata <= {19'h0, step_q, 4'h0, warn_q, err_q, done_q, busy_q};
                default: sw_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // sequencer: walks the step list, one device access or wait at a time
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= S_IDLE;
            step_q <= STP_CLOCK_INPUT_MODE_BIT;
            op_q <= OP_INIT;
            target_q <= 1'b0;
            clock_input_mode_bit_q <= 1'b0;
            pd_en_q <= 1'b0;
            div_en_q <= 1'b0;
            ctl_q <= 32'h0000_0000;
            wait_q <= 16'h0000;
            poll_q <= 16'h0000;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
            warn_q <= 1'b0;
            dev_addr <= 32'h0000_0000;
            dev_wdata <= 32'h0000_0000;
            dev_wr <= 1'b0;
            dev_rd <= 1'b0;
        end
        else
        begin
            dev_wr <= 1'b0;
            dev_rd <= 1'b0;
            unique case (state_q)
                S_IDLE:
                begin
                    if (start_req)
                    begin
                        done_q <= 1'b0;
                        err_q <= !start_ok;
                        // a busy system is allowed but flagged
                        warn_q <= !sw_wdata[CF_TARGET] && !periph_quiet;
                        if (start_ok)
                        begin
                            busy_q <= 1'b1;
                            state_q <= S_STEP;
                            step_q <= STP_CLOCK_INPUT_MODE_BIT;
                            op_q <= pllcs_op_t'(sw_wdata[CF_OP +: 2]);
                            target_q <= sw_wdata[CF_TARGET];
                            clock_input_mode_bit_q <= sw_wdata[CF_CLOCK_INPUT_MODE_BIT];
                            pd_en_q <= sw_wdata[CF_POST_DIVIDER_REG_EN];
                            div_en_q <= sw_wdata[CF_DIV_EN];
                            // start from the after-reset picture of the control word
                            ctl_q <= 32'h0000_0000;
                            ctl_q[CTL_ENSRC_BIT] <= 1'b1;
                            ctl_q[CTL_RST_BIT] <= 1'b1;
                            ctl_q[CTL_PWRDN_BIT] <= pllcs_op_t'(sw_wdata[CF_OP +: 2]) == OP_INIT;
                            ctl_q[CTL_CLOCK_INPUT_MODE_BIT_BIT] <= sw_wdata[CF_CLOCK_INPUT_MODE_BIT];
                        end
                    end
                end
                S_STEP:
                begin
                    if (step_q == STP_END)
                    begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        state_q <= S_IDLE;
                    end
                    else if (!step_used(step_q, op_q, target_q, pd_en_q, div_en_q))
                        step_q <= step_q + 5'h01;
                    else if (step_kind(step_q) == K_WAIT)
                    begin
                        state_q <= S_WAIT;
                        case (step_q)
                            STP_BYP_WAIT: wait_q <= 16'(BYPASS_CYC);
                            STP_STAB_WAIT: wait_q <= stab_q;
                            STP_RST_WAIT: wait_q <= rstw_q;
                            default: wait_q <= lock_q;
                        endcase
                    end
                    else if (step_kind(step_q) == K_POLL)
                    begin
                        state_q <= S_READ;
                        poll_q <= 16'h0000;
                        dev_rd <= 1'b1;
                        dev_addr <= base + {20'h0, OFF_STAT};
                    end
                    else
                    begin
                        // one write per step, the next step follows the cycle after
                        dev_wr <= 1'b1;
                        step_q <= step_q + 5'h01;
                        case (step_q)
                            STP_MULT:
                            begin
                                dev_addr <= base + {20'h0, OFF_MULT};
                                dev_wdata <= mult_q;
                            end
                            STP_POST_DIVIDER_REG:
                            begin
                                dev_addr <= base + {20'h0, OFF_POST_DIVIDER_REG};
                                dev_wdata <= post_divider_reg_q;
                            end
                            STP_DIV1:
                            begin
                                dev_addr <= base + {20'h0, OFF_DIV1};
                                dev_wdata <= div1_q;
                            end
                            STP_DIV2:
                            begin
                                dev_addr <= base + {20'h0, OFF_DIV2};
                                dev_wdata <= div2_q;
                            end
                            STP_GO_SET_BIT:
                            begin
                                dev_addr <= base + {20'h0, OFF_CMD};
                                dev_wdata <= 32'h0000_0001 << CMD_GO_SET_BIT_BIT;
                            end
                            default:
                            begin
                                dev_addr <= base + {20'h0, OFF_CTL};
                                dev_wdata <= ctl_after(step_q, ctl_q);
                                ctl_q <= ctl_after(step_q, ctl_q);
                            end
                        endcase
                    end
                end
                S_WAIT:
                begin
                    // a zero count still spends one cycle here
                    if (wait_q <= 16'h0001)
                    begin
                        state_q <= S_STEP;
                        step_q <= step_q + 5'h01;
                    end
                    else
                        wait_q <= wait_q - 16'h0001;
                end
                S_READ:
                    state_q <= S_CHECK;
                S_CHECK:
                begin
                    if (!dev_rdata[STAT_GO_STATUS_BIT_BIT])
                    begin
                        state_q <= S_STEP;
                        step_q <= step_q + 5'h01;
                    end
                    else if (poll_q >= 16'(POLL_MAX - 1))
                    begin
                        // a stuck transition ends the run rather than hanging it
                        err_q <= 1'b1;
                        busy_q <= 1'b0;
                        state_q <= S_IDLE;
                    end
                    else
                    begin
                        poll_q <= poll_q + 16'h0001;
                        state_q <= S_READ;
                        dev_rd <= 1'b1;
                    end
                end
            endcase
        end
    end

    // helper counters for the checks below; writes matched on the full device address
    logic wr_ctl, wr_mult, wr_div2, wr_cmd, wr_post_divider_reg;
    logic [15:0] since_byp_q;
    logic [16:0] since_dis_q;
    logic div2_seen_q;
    assign wr_ctl = dev_wr && dev_addr == base + {20'h0, OFF_CTL};
    assign wr_mult = dev_wr && dev_addr == base + {20'h0, OFF_MULT};
    assign wr_div2 = dev_wr && dev_addr == base + {20'h0, OFF_DIV2};
    assign wr_cmd = dev_wr && dev_addr == base + {20'h0, OFF_CMD};
    assign wr_post_divider_reg = dev_wr && dev_addr == base + {20'h0, OFF_POST_DIVIDER_REG};
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            since_byp_q <= 16'h0000;
            since_dis_q <= 17'h0_0000;
            div2_seen_q <= 1'b0;
        end
        else
        begin
            // restarts at every bypass write, so the last one before the reset step counts
            if (wr_ctl && !dev_wdata[CTL_EN_BIT])
                since_byp_q <= 16'h0001;
            else if (since_byp_q != 16'h0000 && since_byp_q != 16'hFFFF)
                since_byp_q <= since_byp_q + 16'h0001;
            // one bit wider than the wait count so a full-scale wait cannot saturate it
            if (state_q == S_STEP && step_q == STP_DIS_CLR)
                since_dis_q <= 17'h0_0000;
            else if (since_dis_q != 17'h1_FFFF)
                since_dis_q <= since_dis_q + 17'h0_0001;
            if (state_q == S_IDLE)
                div2_seen_q <= 1'b0;
            else if (wr_div2)
                div2_seen_q <= 1'b1;
        end
    end

    sequence s_go_busy;
        state_q == S_CHECK && dev_rdata[STAT_GO_STATUS_BIT_BIT] && poll_q < 16'(POLL_MAX - 1);
    endsequence
    sequence s_reread;
        dev_rd && state_q == S_READ ##1 state_q == S_CHECK;
    endsequence

    strobe_excl_a: assert property (@(posedge clk) disable iff (!rst_b) !(dev_wr && dev_rd))
        else $error("device read and write strobes together");
    bypass_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == S_STEP && step_q == STP_RST_CLR && op_q != OP_DIV)
        |-> since_byp_q > 16'(BYPASS_CYC))
        else $error("pll reset cleared too soon after bypass select");
    mult_bypass_a: assert property (@(posedge clk) disable iff (!rst_b)
        wr_mult |-> !ctl_q[CTL_EN_BIT] && !ctl_q[CTL_RST_BIT])
        else $error("multiplier written outside bypass and reset");
    power_up_a: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_ctl && $fell(ctl_q[CTL_PWRDN_BIT]))
        |-> ctl_q[CTL_DIS_BIT] && !ctl_q[CTL_RST_BIT])
        else $error("power-down left without output disabled in reset");
    stab_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_mult && op_q == OP_INIT) |-> since_dis_q > {1'b0, stab_q})
        else $error("multiplier written before stabilization time");
    go_order_a: assert property (@(posedge clk) disable iff (!rst_b)
        wr_cmd |-> div2_seen_q)
        else $error("go set before divider ratios written");
    go_poll_a: assert property (@(posedge clk) disable iff (!rst_b)
        s_go_busy |=> s_reread)
        else $error("sequence moved on while go status set");
    no_post_divider_reg_a: assert property (@(posedge clk) disable iff (!rst_b)
        wr_post_divider_reg |-> dev_addr[11:8] == SYS_BASE[11:8] + 4'h1)
        else $error("post-divider written on memory-side controller");
    leave_bypass_a: assert property (@(posedge clk) disable iff (!rst_b)
        (dev_wr && $rose(ctl_q[CTL_EN_BIT])) |-> ctl_q[CTL_RST_BIT] && $past(state_q) == S_STEP)
        else $error("bypass left with pll still in reset");
endmodule

// *** pllcs_dev.sv ***
// behavioural register model of the two pll controllers
module pllcs_dev
    import pllcs_pkg::*;
#(
    parameter int GO_CYC = 5
)(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [31:0] dev_addr,
    input wire logic [31:0] dev_wdata,
    input wire logic dev_wr,
    input wire logic dev_rd,
    output logic [31:0] dev_rdata
);
    logic [31:0] r [0:31];
    logic [7:0] go_q;
    logic [7:0] byp_q;
    logic [4:0] ix;
    logic [31:0] c;
    int viol;
    logic [1:0] fwd;
    assign ix = {dev_addr[10], dev_addr[5:2]};
    assign c = r[{dev_addr[10], 4'h0}];
    // domain clocks follow the pll only once select is set, the bypass clock otherwise
    assign fwd = {r[16][CTL_EN_BIT], r[0][CTL_EN_BIT]};
    // register file, go timer and ordering watch; misuse bumps viol
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < 32; i++)
                r[i] <= 32'h0;
            r[0] <= 32'h0000_0022; // powered down, bypass
            r[16] <= 32'h0000_0022;
            r[22] <= RV_DIV1;
            r[23] <= RV_DIV2;
            go_q <= 8'h00;
            byp_q <= 8'h00;
            viol <= 0;
            dev_rdata <= 32'h0;
        end
        else
        begin
            byp_q <= (byp_q == 8'hFF) ? byp_q : byp_q + 8'h01;
            go_q <= (go_q != 8'h00) ? go_q - 8'h01 : go_q;
            // a released read bus flips to the inverse every cycle, so the last data shows again every other cycle
            dev_rdata <= ~dev_rdata;
            if (dev_rd)
                dev_rdata <= (ix[3:0] == 4'hF) ? {31'h0, go_q != 8'h00} : r[ix];
            if (dev_wr)
            begin
                r[ix] <= dev_wdata;
                if (ix[3:0] == 4'h0 && !dev_wdata[CTL_EN_BIT] && dev_wdata[CTL_RST_BIT])
                    byp_q <= 8'h00;
                if (ix[3:0] == 4'h0 && c[CTL_RST_BIT] && !dev_wdata[CTL_RST_BIT]
                    && (byp_q < 8'h1D || c[CTL_EN_BIT] || c[CTL_ENSRC_BIT]))
                    viol <= viol + 1;
                if (ix[3:0] == 4'h0 && c[CTL_PWRDN_BIT] && !dev_wdata[CTL_PWRDN_BIT]
                    && !c[CTL_DIS_BIT])
                    viol <= viol + 1;
                if (ix[3:0] == 4'h0 && dev_wdata[CTL_EN_BIT] && !c[CTL_EN_BIT]
                    && (!c[CTL_RST_BIT] || c[CTL_DIS_BIT]))
                    viol <= viol + 1;
                if (ix[3:0] == 4'h4 && (c[CTL_RST_BIT] || c[CTL_EN_BIT]))
                    viol <= viol + 1;
                if (ix == 5'h1A || (ix[3:0] == 4'hE && go_q != 8'h00))
                    viol <= viol + 1;
                if (ix[3:0] == 4'hE && dev_wdata[CMD_GO_SET_BIT_BIT])
                    go_q <= GO_CYC[7:0];
            end
        end
    end
endmodule

// *** tb.sv ***
// self-checking bench for the pll sequencer host
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import pllcs_pkg::*;
    logic clk, rst_b, sw_wr, sw_rd, mem_quiet, periph_quiet, dev_wr, dev_rd;
    logic [7:0] sw_addr;
    logic [31:0] sw_wdata, sw_rdata, dev_addr, dev_wdata, dev_rdata, s;
    int n_mismatch, num_checks;
    pllcs_host #(.POLL_MAX(8)) pllcs_host_inst (.clk(clk), .rst_b(rst_b),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .mem_quiet(mem_quiet), .periph_quiet(periph_quiet),
        .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr),
        .dev_rd(dev_rd), .dev_rdata(dev_rdata));
    pllcs_dev pllcs_dev_inst (.clk(clk), .rst_b(rst_b), .dev_addr(dev_addr),
        .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata));
    always #2.5 clk = ~clk;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask
    // start a sequence and poll status until busy drops, bounded
    task automatic run(input logic [31:0] c);
        wr(SW_CTRL, c);
        for (int i = 0; i < 400; i++)
        begin
            rd(SW_STATUS, s);
            if (s[SF_BUSY] === 1'b0)
                break;
        end
    endtask
    task automatic t_reset();
        logic [31:0] d;
        logic [7:0] a [5] = '{SW_MULT, SW_DIV1, SW_DIV2, SW_STATUS, 8'h3C};
        logic [31:0] e [5] = '{RV_MULT, RV_DIV1, RV_DIV2, 32'h0, 32'h0};
        for (int i = 0; i < 5; i++)
        begin
            rd(a[i], d);
            chk("sw reg", e[i], d);
        end
    endtask
    task automatic t_init();
        wr(SW_STAB, 32'h4);
        wr(SW_RSTW, 32'h4);
        wr(SW_LOCK, 32'h4);
        wr(SW_MULT, 32'h15);
        wr(SW_POST_DIVIDER_REG, 32'h8001);
        run(32'h31);
        chk("init status", 32'h2, s & 32'hF);
        chk("sys ctl", 32'h109, pllcs_dev_inst.r[0] & 32'h13B);
        chk("sys mult", 32'h15, pllcs_dev_inst.r[4]);
        chk("sys post_divider_reg", 32'h8001, pllcs_dev_inst.r[10]);
    endtask
    task automatic t_mult();
        @(posedge clk) periph_quiet <= 1'b0;
        wr(SW_MULT, 32'h11);
        run(32'h3);
        chk("mult status", 32'hA, s & 32'hF);
        chk("sys mult", 32'h11, pllcs_dev_inst.r[4]);
        chk("sys ctl", 32'h09, pllcs_dev_inst.r[0] & 32'h3B);
    endtask
    task automatic t_mem();
        @(posedge clk) periph_quiet <= 1'b1;
        run(32'h49);
        chk("mem busy status", 32'h4, s & 32'hF);
        chk("pll forwarded", 32'h1, {30'h0, pllcs_dev_inst.fwd});
        @(posedge clk) mem_quiet <= 1'b1;
        wr(SW_DIV1, 32'h8004);
        run(32'h49);
        chk("mem status", 32'h2, s & 32'hF);
        chk("mem div1", 32'h8004, pllcs_dev_inst.r[22]);
        chk("mem ctl", 32'h09, pllcs_dev_inst.r[16] & 32'h3B);
        run(32'h5);
        chk("sys div status", 32'h4, s & 32'hF);
        wr(SW_DIV2, 32'h8003);
        run(32'h4D);
        chk("div status", 32'h2, s & 32'hF);
        chk("mem div2", 32'h8003, pllcs_dev_inst.r[23]);
        chk("order faults", 32'h0, pllcs_dev_inst.viol);
        chk("pll forwarded", 32'h3, {30'h0, pllcs_dev_inst.fwd});
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        rst_b = 1'b0;
        {sw_wr, sw_rd, mem_quiet} = 3'h0;
        periph_quiet = 1'b1;
        sw_addr = 8'h00;
        sw_wdata = 32'h0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_init();
        t_mult();
        t_mem();
        conclude();
    end
    // watchdog well beyond the few hundred cycles the sequences need
    initial
    begin
        #100000;
        n_mismatch++;
        conclude();
    end
endmodule
